// ==== vtsp_packetizer.sv ====
// transport stream packetizer: channel word, optional timestamps, 16-bit body words
// assumes an APB master, a byte-wide encoder upstream and a header/trailer stage downstream
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/100ps
// Overview of operation
// - payload kind sits in channel bits 27-24
// - channel bit 23 gives byte order
// - order zero: earlier byte in high half
// - order one: earlier byte in low half
// - channel bits 22-0 stay zero
// - optional 64-bit stamp precedes each sync byte
// - stamp low time word then high word
// - relative time, high 16 bits zero
// - absolute time replaces relative when enabled
// - only whole 188-byte transport packets emitted
// - header time taken at first packet start
// - every transport packet starts with 0x47
// - exactly 187 bytes follow the sync byte
// - channel word low half then high half
// - channel bit 30 marks stamps present
// - channel bit 31 marks embedded time
// - channel bit 29 marks clock sync
// - channel bit 28 marks metadata present
module vtsp_packetizer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ts_valid,
	input wire logic [7:0] ts_data,
	output logic ts_ready,
	input wire logic [47:0] rtc_time,
	input wire logic [63:0] abs_time,
	output logic out_valid,
	output vtsp_pkg::vtsp_word_s out_word,
	input wire logic out_ready,
	output logic [47:0] hdr_time,
	output logic hdr_time_valid
);
	// all state of the block
	typedef struct packed {
		vtsp_pkg::vtsp_state_e state;
		logic [31:0] ctrl; // control register
		logic [31:0] cw; // channel word latched per data packet
		logic [63:0] stamp; // time of the buffered transport packet
		logic [7:0] pend; // even byte waiting for its partner
		logic [7:0] bcnt; // byte index inside transport packet
		logic [6:0] addr; // body word being read
		logic [1:0] sub; // half-word index in channel and stamp
		logic [7:0] tsn; // transport packets already in this data packet
		logic [7:0] pcnt; // data packets completed
		logic rd_ok; // read data matches addr
		logic resync; // a byte was dropped hunting for sync
		logic ts_ready;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [47:0] hdr_time;
		logic hdr_valid;
		logic v0; // buffer head valid
		logic v1; // buffer tail valid
		vtsp_pkg::vtsp_word_s e0; // buffer head
		vtsp_pkg::vtsp_word_s e1; // buffer tail
	} vtsp_top_s;

	vtsp_top_s r;
	vtsp_top_s next_r;
	logic wr_en; // store one body word
	logic [6:0] wr_addr;
	logic [15:0] wr_data;
	logic [15:0] rd_data; // registered body word
	logic accept; // byte taken from the encoder
	logic push; // word enters the two-entry buffer
	logic src_ok; // current source word is ready
	vtsp_pkg::vtsp_word_s src; // current source word
	logic [7:0] tp_count; // transport packets per data packet
	logic pkt_end; // this transport packet closes the data packet

	// channel word from the control register, reserved bits forced to zero
	function automatic logic [31:0] build_cw(input logic [31:0] c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[vtsp_pkg::CW_ET] = c[vtsp_pkg::CTL_ET];
		w[vtsp_pkg::CW_IPH] = c[vtsp_pkg::CTL_IPH];
		w[vtsp_pkg::CW_SYNC] = c[vtsp_pkg::CTL_SYNC];
		w[vtsp_pkg::CW_META] = c[vtsp_pkg::CTL_META];
		w[vtsp_pkg::CW_KIND_LSB +: 4] = c[vtsp_pkg::CTL_KIND_LSB +: 4];
		w[vtsp_pkg::CW_ORDER] = c[vtsp_pkg::CTL_ORDER];
		return w;
	endfunction

	// pair an earlier and a later byte into one word by byte order
	function automatic logic [15:0] pair_bytes(input logic [7:0] early, input logic [7:0] late, input logic order);
		logic [15:0] w;
		w = order ? {late, early} : {early, late};
		return w;
	endfunction

	// a zero count closes a data packet after every transport packet, same as one
	assign tp_count = (r.ctrl[vtsp_pkg::CTL_COUNT_LSB +: 8] == 8'h00) ? 8'h01 : r.ctrl[vtsp_pkg::CTL_COUNT_LSB +: 8];
	assign accept = ts_valid && r.ts_ready;
	assign pkt_end = ({1'b0, r.tsn} + 9'h001) >= {1'b0, tp_count};

	vtsp_ts_ram #(
		.DEPTH(vtsp_pkg::TS_WORDS),
		.AW(7)
	) u_ram (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_addr(r.addr),
		.rd_data(rd_data)
	);

	// source word chosen by the sequencer
	always_comb begin
		src = '0;
		src_ok = 1'b0;
		case (r.state)
			vtsp_pkg::S_CHAN: begin
				src.first = (r.sub == 2'h0);
				src.data = (r.sub == 2'h0) ? r.cw[15:0] : r.cw[31:16];
				src_ok = 1'b1;
			end
			vtsp_pkg::S_STAMP: begin
				src.data = r.stamp[{r.sub, 4'h0} +: 16];
				src_ok = 1'b1;
			end
			vtsp_pkg::S_BODY: begin
				src.data = rd_data;
				src.last = (r.addr == vtsp_pkg::TS_LAST_WORD) && pkt_end;
				src_ok = r.rd_ok; // registered read needs one settled cycle
			end
			default: begin
				src_ok = 1'b0;
			end
		endcase
		push = src_ok && !r.v1;
	end

	// next state: bus slave, sequencer, two-entry buffer
	always_comb begin
		next_r = r;
		wr_en = 1'b0;
		wr_addr = 7'h00;
		wr_data = 16'h0000;
		next_r.hdr_valid = 1'b0;
		// apb: answer one cycle into the access phase
		next_r.pready = 1'b0;
		next_r.pslverr = 1'b0;
		if (psel && penable && !r.pready) begin
			next_r.pready = 1'b1;
			next_r.prdata = 32'h0000_0000;
			case (paddr)
				vtsp_pkg::OFF_CTRL: begin
					next_r.prdata = r.ctrl;
				end
				vtsp_pkg::OFF_STAT: begin
					next_r.prdata[vtsp_pkg::STAT_RESYNC] = r.resync;
					next_r.prdata[vtsp_pkg::STAT_BUSY] = (r.state != vtsp_pkg::S_IDLE);
					next_r.prdata[vtsp_pkg::STAT_COUNT_LSB +: 8] = r.pcnt;
				end
				vtsp_pkg::OFF_CHAN: begin
					next_r.prdata = r.cw;
				end
				default: begin
					next_r.pslverr = 1'b1; // unmapped
				end
			endcase
		end
		// writes land on the completing edge
		if (psel && penable && r.pready && pwrite) begin
			if (paddr == vtsp_pkg::OFF_CTRL) begin
				next_r.ctrl = pwdata;
			end else if (paddr == vtsp_pkg::OFF_STAT && pwdata[vtsp_pkg::STAT_RESYNC]) begin
				next_r.resync = 1'b0; // write one to clear; a new drop below wins
			end
		end
		// sequencer
		case (r.state)
			vtsp_pkg::S_IDLE: begin
				next_r.tsn = 8'h00;
				next_r.bcnt = 8'h00;
				if (r.ctrl[vtsp_pkg::CTL_EN]) begin
					next_r.state = vtsp_pkg::S_FILL;
				end
			end
			vtsp_pkg::S_FILL: begin
				if (accept) begin
					if (r.bcnt == 8'h00 && ts_data != vtsp_pkg::SYNC_BYTE) begin
						next_r.resync = 1'b1;
					end else begin
						if (r.bcnt == 8'h00) begin
							// time of the first bit of this transport packet
							next_r.stamp = r.ctrl[vtsp_pkg::CTL_ABS] ? abs_time : {16'h0000, rtc_time};
							if (r.tsn == 8'h00) begin
								next_r.cw = build_cw(r.ctrl);
								next_r.hdr_time = rtc_time;
								next_r.hdr_valid = 1'b1;
							end
						end
						if (!r.bcnt[0]) begin
							next_r.pend = ts_data;
						end else begin
							wr_en = 1'b1;
							wr_addr = r.bcnt[7:1];
							wr_data = pair_bytes(r.pend, ts_data, r.cw[vtsp_pkg::CW_ORDER]);
						end
						if (r.bcnt == vtsp_pkg::TS_LAST_BYTE) begin
							// whole packet stored, only now is anything emitted
							next_r.bcnt = 8'h00;
							next_r.sub = 2'h0;
							next_r.addr = 7'h00;
							if (r.tsn == 8'h00) begin
								next_r.state = vtsp_pkg::S_CHAN;
							end else if (r.cw[vtsp_pkg::CW_IPH]) begin
								next_r.state = vtsp_pkg::S_STAMP;
							end else begin
								next_r.state = vtsp_pkg::S_BODY;
							end
						end else begin
							next_r.bcnt = r.bcnt + 8'h01;
						end
					end
				end else if (r.bcnt == 8'h00 && r.tsn == 8'h00 && !r.ctrl[vtsp_pkg::CTL_EN]) begin
					next_r.state = vtsp_pkg::S_IDLE; // stop only between data packets
				end
			end
			vtsp_pkg::S_CHAN: begin
				if (push) begin
					if (r.sub == 2'h1) begin
						next_r.sub = 2'h0;
						next_r.state = r.cw[vtsp_pkg::CW_IPH] ? vtsp_pkg::S_STAMP : vtsp_pkg::S_BODY;
					end else begin
						next_r.sub = 2'h1;
					end
				end
			end
			vtsp_pkg::S_STAMP: begin
				if (push) begin
					next_r.sub = r.sub + 2'h1;
					if (r.sub == 2'h3) begin
						next_r.state = vtsp_pkg::S_BODY;
					end
				end
			end
			vtsp_pkg::S_BODY: begin
				if (push) begin
					if (r.addr == vtsp_pkg::TS_LAST_WORD) begin
						next_r.addr = 7'h00;
						if (pkt_end) begin
							next_r.tsn = 8'h00;
							next_r.pcnt = r.pcnt + 8'h01;
							next_r.state = r.ctrl[vtsp_pkg::CTL_EN] ? vtsp_pkg::S_FILL : vtsp_pkg::S_IDLE;
						end else begin
							next_r.tsn = r.tsn + 8'h01;
							next_r.state = vtsp_pkg::S_FILL;
						end
					end else begin
						next_r.addr = r.addr + 7'h01;
					end
				end
			end
			default: begin
				next_r.state = vtsp_pkg::S_IDLE;
			end
		endcase
		next_r.rd_ok = (r.state == vtsp_pkg::S_BODY) && !push;
		next_r.ts_ready = (next_r.state == vtsp_pkg::S_FILL);
		// two-entry buffer: pop shifts the tail forward, push fills the free slot
		if (r.v0 && out_ready) begin
			next_r.e0 = r.e1;
			next_r.v0 = r.v1;
			next_r.v1 = 1'b0;
		end
		if (push) begin
			if (!next_r.v0) begin
				next_r.e0 = src;
				next_r.v0 = 1'b1;
			end else begin
				next_r.e1 = src;
				next_r.v1 = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.ctrl <= vtsp_pkg::CTL_RESET;
		end else begin
			r <= next_r;
		end
	end

	// outputs straight from flip-flops
	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign ts_ready = r.ts_ready;
	assign out_valid = r.v0;
	assign out_word = r.e0;
	assign hdr_time = r.hdr_time;
	assign hdr_time_valid = r.hdr_valid;

	// checks
	logic body_push0; // first body word entering the buffer
	assign body_push0 = push && r.state == vtsp_pkg::S_BODY && r.addr == 7'h00;

	sequence s_fill_exit;
		r.state != vtsp_pkg::S_FILL && $past(r.state) == vtsp_pkg::S_FILL;
	endsequence
	sequence s_body_entry;
		r.state == vtsp_pkg::S_BODY && $past(r.state) != vtsp_pkg::S_BODY;
	endsequence

	property p_sync_high;
		@(posedge pclk) disable iff (!presetn)
		body_push0 && !r.cw[vtsp_pkg::CW_ORDER] |-> src.data[15:8] == 8'h47;
	endproperty
	a_sync_high: assert property (p_sync_high) else $error("sync byte not in high half");

	property p_sync_low;
		@(posedge pclk) disable iff (!presetn)
		body_push0 && r.cw[vtsp_pkg::CW_ORDER] |-> src.data[7:0] == 8'h47;
	endproperty
	a_sync_low: assert property (p_sync_low) else $error("sync byte not in low half");

	property p_reserved;
		@(posedge pclk) disable iff (!presetn)
		r.cw[22:0] == 23'h000000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved channel bits set");

	property p_whole_packet;
		@(posedge pclk) disable iff (!presetn)
		(s_fill_exit and (r.state != vtsp_pkg::S_IDLE)) |-> $past(accept) && $past(r.bcnt) == 8'hbb;
	endproperty
	a_whole_packet: assert property (p_whole_packet) else $error("left fill before byte 187");

	property p_stamp_order;
		@(posedge pclk) disable iff (!presetn)
		s_body_entry |-> ($past(r.state) == vtsp_pkg::S_STAMP) == r.cw[vtsp_pkg::CW_IPH];
	endproperty
	a_stamp_order: assert property (p_stamp_order) else $error("stamp presence disagrees with channel bit 30");

	property p_stamp_zero;
		@(posedge pclk) disable iff (!presetn)
		push && r.state == vtsp_pkg::S_STAMP && r.sub == 2'h3 && !r.ctrl[vtsp_pkg::CTL_ABS] |-> src.data == 16'h0000;
	endproperty
	a_stamp_zero: assert property (p_stamp_zero) else $error("relative stamp top bits not zero");

	property p_hdr_time;
		@(posedge pclk) disable iff (!presetn)
		r.hdr_valid |-> $past(accept) && $past(r.bcnt) == 8'h00 && $past(r.tsn) == 8'h00 && r.hdr_time == $past(rtc_time);
	endproperty
	a_hdr_time: assert property (p_hdr_time) else $error("header time not from first packet start");

	property p_chan_pair;
		@(posedge pclk) disable iff (!presetn)
		r.v0 && r.e0.first && out_ready |=> r.v0 && r.e0.data == r.cw[31:16];
	endproperty
	a_chan_pair: assert property (p_chan_pair) else $error("channel high half does not follow low half");

	property p_hold;
		@(posedge pclk) disable iff (!presetn)
		out_valid && !out_ready |=> out_valid && $stable(out_word);
	endproperty
	a_hold: assert property (p_hold) else $error("buffer dropped a stalled word");
endmodule

// ==== vtsp_pkg.sv ====
// constants and types of the video transport stream packetizer
// assumes a single 250 MHz clock domain and a byte-wide transport input
package vtsp_pkg;
	// transport packet geometry
	localparam int TS_BYTES = 188; // sync byte plus 187 data bytes
	localparam int TS_WORDS = TS_BYTES / 2; // 16-bit words per transport packet
	localparam logic [7:0] TS_LAST_BYTE = 8'hbb; // index of byte 187
	localparam logic [6:0] TS_LAST_WORD = 7'h5d; // index of word 93
	localparam logic [7:0] SYNC_BYTE = 8'h47; // 01000111
	// payload kinds, 4'h4 and up reserved
	localparam logic [3:0] KIND_MPEG2_MPML = 4'h0;
	localparam logic [3:0] KIND_H264_L21 = 4'h1;
	localparam logic [3:0] KIND_H264_L22 = 4'h2;
	localparam logic [3:0] KIND_H264_L3 = 4'h3;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_CHAN = 8'h08;
	// control register fields
	localparam int CTL_KIND_LSB = 0;
	localparam int CTL_ORDER = 4;
	localparam int CTL_ET = 5;
	localparam int CTL_IPH = 6;
	localparam int CTL_SYNC = 7;
	localparam int CTL_META = 8;
	localparam int CTL_ABS = 9;
	localparam int CTL_COUNT_LSB = 16;
	localparam int CTL_EN = 31;
	localparam logic [31:0] CTL_RESET = 32'h0001_0000; // disabled, one transport packet per data packet
	// status register fields
	localparam int STAT_RESYNC = 0;
	localparam int STAT_BUSY = 1;
	localparam int STAT_COUNT_LSB = 8;
	// channel word fields
	localparam int CW_ET = 31;
	localparam int CW_IPH = 30;
	localparam int CW_SYNC = 29;
	localparam int CW_META = 28;
	localparam int CW_KIND_LSB = 24;
	localparam int CW_ORDER = 23;
	// sequencer states, gray along fill, channel, stamp, body
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_FILL = 3'h1,
		S_CHAN = 3'h3,
		S_STAMP = 3'h2,
		S_BODY = 3'h6
	} vtsp_state_e;
	// one 16-bit word of packet body with framing marks
	typedef struct packed {
		logic first; // first word of the data packet, the channel word low half
		logic last; // last word of the data packet
		logic [15:0] data;
	} vtsp_word_s;
endpackage

// ==== vtsp_ts_ram.sv ====
// one-transport-packet word store with registered read data
// assumes writer and reader never touch the same word in one cycle
`timescale 1ns/100ps
module vtsp_ts_ram #(
	parameter int DEPTH = 94,
	parameter int AW = 7
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [15:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [15:0] rd_data
);
	// refuse a store too small for a transport packet or an address too narrow
	if (DEPTH < vtsp_pkg::TS_WORDS || (1 << AW) < DEPTH) begin : g_bad_size
		$error("vtsp_ts_ram: depth or address width unusable");
	end

	typedef struct packed {
		logic [DEPTH-1:0][15:0] mem; // word array
		logic [15:0] rdata; // read register
	} vtsp_ram_s;

	vtsp_ram_s r;
	vtsp_ram_s next_r;

	// write port and read register
	always_comb begin
		next_r = r;
		if (wr_en) begin
			next_r.mem[wr_addr] = wr_data;
		end
		next_r.rdata = r.mem[rd_addr]; // old data on a collision
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign rd_data = r.rdata;
endmodule

// ==== vtsp_encoder_model.sv ====
// behavioural upstream encoder: bursts of whole transport packets
// assumes the byte handshake of the packetizer, one clock domain
`timescale 1ns/100ps
module vtsp_encoder_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go, // one-cycle start of a burst
	input wire logic [3:0] n_pkt, // transport packets in the burst
	input wire logic bad_lead, // one stray byte before the first sync
	input wire logic ts_ready,
	output logic ts_valid,
	output logic [7:0] ts_data,
	output logic busy
);
	int left; // bytes still owed in the burst
	int idx; // byte position in the transport packet
	logic stray; // stray byte still to be sent
	// byte is held until taken; idle data toggles so nothing stale looks valid
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ts_valid <= 1'b0;
			ts_data <= 8'h00;
			busy <= 1'b0;
			left = 0;
			idx = 0;
			stray = 1'b0;
		end else begin
			if (ts_valid && ts_ready) begin
				if (stray) begin
					stray = 1'b0;
				end else begin
					left = left - 1;
					idx = (idx == 187) ? 0 : idx + 1;
				end
			end
			if (go && !busy) begin
				left = n_pkt * 188;
				idx = 0;
				stray = bad_lead;
			end
			if (!ts_valid || ts_ready) begin
				// random gaps between bytes
				if (left > 0 && $urandom_range(3) != 0) begin
					ts_valid <= 1'b1;
					ts_data <= stray ? 8'h5a : (idx == 0) ? vtsp_pkg::SYNC_BYTE : 8'($urandom);
				end else begin
					ts_valid <= 1'b0;
					ts_data <= ~ts_data;
				end
			end
			busy <= (left > 0);
		end
	end
endmodule

// ==== testbench.sv ====
// self-checking bench of the transport stream packetizer
// assumes vtsp_pkg, vtsp_packetizer and vtsp_encoder_model compiled first
`timescale 1ns/100ps
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, rerr;
	logic ts_valid, ts_ready, enc_busy;
	logic [7:0] ts_data, held;
	logic [47:0] rtc_time = 48'h0, hdr_time;
	logic [63:0] abs_time = 64'h0, stamp;
	logic out_valid, hdr_time_valid;
	logic out_ready = 1'b0, hold = 1'b0, go = 1'b0, bad_lead = 1'b0;
	logic [3:0] n_pkt = 4'h0;
	vtsp_pkg::vtsp_word_s out_word;
	vtsp_pkg::vtsp_word_s exp_q[$]; // predicted output words
	logic [47:0] hdr_q[$]; // predicted header times
	logic [31:0] ctrl = 32'h0, cw;
	int in_idx = 0, ts_in_dp = 0, cfg_n = 1, n_dp = 0;
	int n_mismatch = 0, tests_run = 0;
	always #2 pclk = ~pclk;
	vtsp_packetizer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ts_valid(ts_valid), .ts_data(ts_data), .ts_ready(ts_ready), .rtc_time(rtc_time),
		.abs_time(abs_time), .out_valid(out_valid), .out_word(out_word), .out_ready(out_ready),
		.hdr_time(hdr_time), .hdr_time_valid(hdr_time_valid));
	vtsp_encoder_model enc (.pclk(pclk), .presetn(presetn), .go(go), .n_pkt(n_pkt), .bad_lead(bad_lead),
		.ts_ready(ts_ready), .ts_valid(ts_valid), .ts_data(ts_data), .busy(enc_busy));
	// free-running relative time, random absolute time and a randomly stalling receiver
	always @(posedge pclk) begin
		rtc_time <= rtc_time + 48'h1;
		abs_time <= {$urandom, $urandom};
		out_ready <= !hold && $urandom_range(3) != 0;
	end
	task automatic fail(input string msg);
		n_mismatch++;
		$display("mismatch at %0t: %s", $time, msg);
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
		tests_run++;
		if (got !== exp) fail(msg);
	endtask
	task automatic chk_word(input vtsp_pkg::vtsp_word_s got, input vtsp_pkg::vtsp_word_s exp);
		tests_run++;
		if (got !== exp) fail("output word");
	endtask
	// expected channel word from the control bits
	function automatic logic [31:0] cw_of(input logic [31:0] c);
		return {c[5], c[6], c[7], c[8], c[3:0], c[4], 23'h0};
	endfunction
	function automatic void put(input logic f, input logic l, input logic [15:0] d);
		exp_q.push_back({f, l, d});
	endfunction
	// apb transfer; held until pready seen at an edge
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdata;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (i >= 50) fail("apb timeout");
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// input side: predict the word stream from each byte taken
	always @(posedge pclk) begin
		if (presetn && ts_valid === 1'b1 && ts_ready === 1'b1
			&& !(in_idx == 0 && ts_data !== vtsp_pkg::SYNC_BYTE)) begin
			if (in_idx == 0) begin
				cw = cw_of(ctrl);
				if (ts_in_dp == 0) begin
					put(1'b1, 1'b0, cw[15:0]);
					put(1'b0, 1'b0, cw[31:16]);
					hdr_q.push_back(rtc_time);
				end
				stamp = ctrl[9] ? abs_time : {16'h0, rtc_time};
				if (ctrl[6])
					for (int k = 0; k < 4; k++)
						put(1'b0, 1'b0, stamp[16*k +: 16]);
			end
			if (in_idx % 2 == 1)
				put(1'b0, in_idx == 187 && ts_in_dp == cfg_n - 1, ctrl[4] ? {ts_data, held} : {held, ts_data});
			else
				held = ts_data;
			if (in_idx == 187) begin
				in_idx = 0;
				ts_in_dp = (ts_in_dp == cfg_n - 1) ? 0 : ts_in_dp + 1;
			end else begin
				in_idx++;
			end
		end
		if (out_valid === 1'b1 && out_ready === 1'b1) begin
			if (exp_q.size() == 0) fail("unexpected word");
			else chk_word(out_word, exp_q.pop_front());
		end
		if (hdr_time_valid === 1'b1) begin
			if (hdr_q.size() == 0) fail("unexpected header time");
			else chk(hdr_time, hdr_q.pop_front(), "header time");
		end
	end
	// one enabled burst, then channel and status readback
	task automatic run(input logic [31:0] c, input logic [3:0] np, input logic bad);
		int i;
		ctrl = c;
		cfg_n = (c[23:16] == 8'h0) ? 1 : int'(c[23:16]);
		in_idx = 0;
		ts_in_dp = 0;
		apb(1'b1, vtsp_pkg::OFF_CTRL, c | 32'h8000_0000);
		go <= 1'b1;
		n_pkt <= np;
		bad_lead <= bad;
		@(posedge pclk);
		go <= 1'b0;
		hold <= c[8];
		repeat (300) @(posedge pclk);
		hold <= 1'b0;
		i = 0;
		while ((enc_busy || exp_q.size() != 0 || hdr_q.size() != 0) && i < 20000) begin
			@(posedge pclk);
			i++;
		end
		if (i >= 20000) fail("stream stuck");
		apb(1'b0, vtsp_pkg::OFF_CHAN, 32'h0);
		chk(rdat, cw_of(c), "channel word");
		apb(1'b1, vtsp_pkg::OFF_CTRL, c);
		n_dp += np / cfg_n;
		apb(1'b0, vtsp_pkg::OFF_STAT, 32'h0);
		chk({rdat[15:8], rdat[1], rdat[0]}, {8'(n_dp), 1'b0, bad}, "status");
		if (bad) begin
			apb(1'b1, vtsp_pkg::OFF_STAT, 32'h1);
			apb(1'b0, vtsp_pkg::OFF_STAT, 32'h0);
			chk(rdat[0], 1'b0, "resync clear");
		end
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// watchdog well beyond the expected run length
	initial begin
		#200000;
		fail("watchdog");
		stop_test;
	end
	// main sequence: reset values, unmapped access, then each mode
	initial begin
		void'($urandom(32'hd5fa));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, vtsp_pkg::OFF_CTRL, 32'h0);
		chk(rdat, vtsp_pkg::CTL_RESET, "control reset");
		apb(1'b0, vtsp_pkg::OFF_CHAN, 32'h0);
		chk(rdat, 32'h0, "channel reset");
		apb(1'b1, 8'h0c, 32'hffff_ffff);
		chk(rerr, 1'b1, "unmapped write");
		apb(1'b0, 8'h0c, 32'h0);
		chk({rerr, rdat}, {1'b1, 32'h0}, "unmapped read");
		apb(1'b1, vtsp_pkg::OFF_CHAN, 32'hffff_ffff);
		apb(1'b0, vtsp_pkg::OFF_CTRL, 32'h0);
		chk(rdat, vtsp_pkg::CTL_RESET, "control untouched");
		run(32'h0000_0040, 4'h2, 1'b0);
		run(32'h0002_0271, 4'h2, 1'b1);
		run(32'h0003_0182, 4'h3, 1'b0);
		run(32'h0001_0013, 4'h1, 1'b0);
		run(32'h0000_03ff, 4'h1, 1'b0);
		stop_test;
	end
endmodule
